// ===== design/dpm_consts.svh
`ifndef DPM_CONSTS_SVH
`define DPM_CONSTS_SVH

// Register byte offsets
`define DPM_OFF_CTRL   8'h00
`define DPM_OFF_PMCFG  8'h04
`define DPM_OFF_STEP   8'h08
`define DPM_OFF_CNT    8'h0C
`define DPM_OFF_GAIN   8'h10
`define DPM_OFF_LIMIT  8'h14
`define DPM_OFF_RESALO 8'h18
`define DPM_OFF_RESAHI 8'h1C
`define DPM_OFF_RESBLO 8'h20
`define DPM_OFF_RESBHI 8'h24
`define DPM_OFF_STAT   8'h28

// Control fields
`define DPM_CT_DUAL    0
`define DPM_CT_SDIS    1
`define DPM_CT_SSEL    4:2
`define DPM_CT_FRZ     5
`define DPM_CT_CLR     6
`define DPM_CT_RNDD    7
`define DPM_CT_FSEN    8
`define DPM_CT_FSEL    11:9

// Meter configuration fields
`define DPM_PM_SQR     15:0
`define DPM_PM_DLY     23:16
`define DPM_PM_IVL     31:24

// Gain step fields
`define DPM_ST_DBLW    3:0
`define DPM_ST_DABV    7:4
`define DPM_ST_DZRO    11:8
`define DPM_ST_DSAT    15:12
`define DPM_ST_ZMSK    19:16
`define DPM_ST_MD      23:20
`define DPM_ST_THR     31:24

// Counter thresholds and limits
`define DPM_CN_ZERO    3:0
`define DPM_CN_MAX     7:4
`define DPM_LM_AMAX    15:0
`define DPM_LM_AMIN    31:16

// Reset values
`define DPM_RST_WORD   32'h0000_0000
`define DPM_RST_GAIN   24'h001000

// Timing and arithmetic
`define DPM_CHIP_DLY   9'h003
`define DPM_UNIT_LG    10
`define DPM_D_BIAS     5'h03
`define DPM_FRAC       12
`define DPM_MAG_MAX    8'hFF

`endif

// ===== design/dpm_pkg.sv
package dpm_pkg;
   typedef enum logic [1:0] {DPM_IDLE, DPM_DELAY, DPM_RUN} dpm_pm_state_type;
   typedef logic signed [17:0] dpm_smp_type;
   typedef logic [54:0]        dpm_pwr_type;
endpackage

// ===== design/dpm_meter_agc.sv
// Function
// RL1: Square, sum and integrate 18-bit I/Q samples
// RL2: Interval timer counts in 1024-sample units
// RL3: Integration starts three chips plus delay after sync
// RL4: Latch 55-bit accumulator and flag ready
// RL5: Counting continues to interval, then all restart
// RL6: New result overwrites old, fresh ready flag
// RL7: Sync clears all meter counters
// RL8: Dual mode gives two separate path results
// RL9: Integrate over four times count plus one
// RL10: Software keeps interval above integration count
// RL11: Sync source select and per-meter disable
// RL12: Multiply sample by 12.12 gain word
// RL13: Saturate, then round to 3..18 bits
// RL14: Above threshold lowers gain, else raises
// RL15: Gain is base plus shifted-gain adjustment
// RL16: Four step values, 3 to 18
// RL17: Masked-to-zero magnitude counts as zero
// RL18: Zero counter selects the zero step
// RL19: Saturation counter selects the saturated step
// RL20: Below/above threshold steps per sample
// RL21: Software sets threshold near median level
// RL22: Step field holds value minus three
// RL23: Adjustment held at upper and lower limits
// RL24: Freeze bit or sync freezes; clear resets
// RL25: Saturation step beats zero step beats threshold
`timescale 1ns/100ps
`include "dpm_consts.svh"
module dpm_meter_agc #(
   parameter int UNIT_LG = `DPM_UNIT_LG
) (
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire logic [7:0]          addr,
   input  wire logic [31:0]         wdata,
   input  wire logic                wr,
   input  wire logic                rd,
   output logic [31:0]              rdata,
   input  wire logic                s_valid,
   input  dpm_pkg::dpm_smp_type     s_i_a,
   input  dpm_pkg::dpm_smp_type     s_q_a,
   input  dpm_pkg::dpm_smp_type     s_i_b,
   input  dpm_pkg::dpm_smp_type     s_q_b,
   input  wire logic [7:0]          sync_in,
   output logic                     pm_ready,
   output logic                     y_valid,
   output dpm_pkg::dpm_smp_type     y_i,
   output dpm_pkg::dpm_smp_type     y_q
);
   import dpm_pkg::*;

   localparam int CNT_W = 8 + UNIT_LG;

   logic [31:0]            ctrl_ff, pmcfg_ff, step_ff, cnt_ff, limit_ff, rdata_ff;
   logic [23:0]            gain_ff, geff;
   logic [7:0]             sync1_ff, sync2_ff, sync3_ff, mag;
   logic [2:0]             ssel, fsel;
   logic                   pm_sync, freeze, integ_on_ff, pm_ready_ff, run_smp, last_int, wrap;
   logic                   is_zero, is_max, up, y_valid_ff;
   dpm_pm_state_type       st_ff;
   logic [8:0]             dly_cnt_ff, dly_last;
   logic [CNT_W-1:0]       smp_cnt_ff, integ_last, ivl_last;
   dpm_smp_type            smp_i [2], smp_q [2];
   dpm_pwr_type            term [2], acc_ff [2], res_ff [2];
   logic signed [25:0]     adj_ff, gsum, delta, amax_e, amin_e;
   dpm_smp_type            ya, yb, y_i_ff, y_q_ff;
   logic [3:0]             dfield, zc_ff, mc_ff;
   logic [4:0]             dval;

   assign rdata    = rdata_ff;
   assign pm_ready = pm_ready_ff;
   assign y_valid  = y_valid_ff;
   assign y_i      = y_i_ff;
   assign y_q      = y_q_ff;

   // Register writes
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_ff  <= `DPM_RST_WORD;
         pmcfg_ff <= `DPM_RST_WORD;
         step_ff  <= `DPM_RST_WORD;
         cnt_ff   <= `DPM_RST_WORD;
         limit_ff <= `DPM_RST_WORD;
         gain_ff  <= `DPM_RST_GAIN;
      end else if (wr) begin
         case (addr)
            `DPM_OFF_CTRL:  ctrl_ff  <= wdata;
            `DPM_OFF_PMCFG: pmcfg_ff <= wdata;
            `DPM_OFF_STEP:  step_ff  <= wdata;
            `DPM_OFF_CNT:   cnt_ff   <= wdata;
            `DPM_OFF_GAIN:  gain_ff  <= wdata[23:0];
            `DPM_OFF_LIMIT: limit_ff <= wdata;
            default: ;
         endcase
      end
   end

   // Register reads, data valid the cycle after the strobe
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_ff <= `DPM_RST_WORD;
      end else if (rd) begin
         case (addr)
            `DPM_OFF_CTRL:   rdata_ff <= ctrl_ff;
            `DPM_OFF_PMCFG:  rdata_ff <= pmcfg_ff;
            `DPM_OFF_STEP:   rdata_ff <= step_ff;
            `DPM_OFF_CNT:    rdata_ff <= cnt_ff;
            `DPM_OFF_GAIN:   rdata_ff <= {8'h00, gain_ff};
            `DPM_OFF_LIMIT:  rdata_ff <= limit_ff;
            `DPM_OFF_RESALO: rdata_ff <= res_ff[0][31:0];
            `DPM_OFF_RESAHI: rdata_ff <= {9'h000, res_ff[0][54:32]};
            `DPM_OFF_RESBLO: rdata_ff <= res_ff[1][31:0];
            `DPM_OFF_RESBHI: rdata_ff <= {9'h000, res_ff[1][54:32]};
            `DPM_OFF_STAT:   rdata_ff <= {integ_on_ff, st_ff, 3'h0, adj_ff};
            default:         rdata_ff <= `DPM_RST_WORD;
         endcase
      end else begin
         rdata_ff <= `DPM_RST_WORD;
      end
   end

   // Sync pins pass two flops; the third only serves edge detection
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync1_ff <= 8'h00;
         sync2_ff <= 8'h00;
         sync3_ff <= 8'h00;
      end else begin
         sync1_ff <= sync_in;
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
      end
   end

   assign ssel    = ctrl_ff[`DPM_CT_SSEL];
   assign fsel    = ctrl_ff[`DPM_CT_FSEL];
   assign pm_sync = sync2_ff[ssel] & ~sync3_ff[ssel] & ~ctrl_ff[`DPM_CT_SDIS]; // RL11

   // Meter timing
   assign dly_last   = `DPM_CHIP_DLY + {1'b0, pmcfg_ff[`DPM_PM_DLY]}; // RL3
   assign integ_last = CNT_W'({pmcfg_ff[`DPM_PM_SQR], 2'b00}); // RL9
   assign ivl_last   = {pmcfg_ff[`DPM_PM_IVL], {UNIT_LG{1'b1}}}; // RL2
   assign run_smp    = s_valid && (st_ff == DPM_RUN) && !pm_sync;
   assign last_int   = run_smp && integ_on_ff && (smp_cnt_ff == integ_last);
   assign wrap       = run_smp && (smp_cnt_ff == ivl_last);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_ff       <= DPM_IDLE;
         dly_cnt_ff  <= 9'h000;
         smp_cnt_ff  <= '0;
         integ_on_ff <= 1'b0;
      end else if (pm_sync) begin
         st_ff       <= DPM_DELAY; // RL7
         dly_cnt_ff  <= 9'h000;
         smp_cnt_ff  <= '0;
         integ_on_ff <= 1'b1;
      end else if (s_valid) begin
         unique case (st_ff)
            DPM_IDLE: ;
            DPM_DELAY: begin
               if (dly_cnt_ff == dly_last) begin
                  st_ff <= DPM_RUN; // RL3
               end else begin
                  dly_cnt_ff <= dly_cnt_ff + 9'h001;
               end
            end
            DPM_RUN: begin
               if (wrap) begin
                  smp_cnt_ff  <= '0; // RL5
                  integ_on_ff <= 1'b1;
               end else begin
                  smp_cnt_ff <= smp_cnt_ff + CNT_W'(1);
                  if (last_int) begin
                     integ_on_ff <= 1'b0;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pm_ready_ff <= 1'b0;
      end else begin
         pm_ready_ff <= last_int; // RL4 RL6
      end
   end

   assign smp_i[0] = s_i_a;
   assign smp_q[0] = s_q_a;
   assign smp_i[1] = s_i_b;
   assign smp_q[1] = s_q_b;

   // One accumulator per path; the second runs only in dual mode
   for (genvar p = 0; p < 2; p++) begin : g_path
      logic signed [35:0] sq_i;
      logic signed [35:0] sq_q;
      logic               en;
      assign sq_i    = smp_i[p] * smp_i[p]; // RL1
      assign sq_q    = smp_q[p] * smp_q[p];
      assign term[p] = 55'(unsigned'(sq_i)) + 55'(unsigned'(sq_q));
      assign en      = (p == 0) || ctrl_ff[`DPM_CT_DUAL]; // RL8
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            acc_ff[p] <= '0;
            res_ff[p] <= '0;
         end else if (pm_sync) begin
            acc_ff[p] <= '0; // RL7
         end else if (last_int) begin
            if (en) begin
               res_ff[p] <= acc_ff[p] + term[p]; // RL4 RL6
            end
            acc_ff[p] <= '0;
         end else if (run_smp && integ_on_ff && en) begin
            acc_ff[p] <= acc_ff[p] + term[p]; // RL1
         end
      end
   end

   // Gain scaling with saturation and rounding
   function automatic dpm_smp_type scale(dpm_smp_type x, logic [23:0] g, logic [3:0] md, logic rdis);
      logic signed [42:0] pr;
      logic signed [30:0] sh;
      logic signed [18:0] t;
      logic [17:0]        lm;
      dpm_smp_type        s;
      pr = x * $signed({1'b0, g}); // RL12
      sh = 31'(pr >>> `DPM_FRAC);
      if (sh > 31'sh1FFFF) begin
         s = 18'sh1FFFF; // RL13
      end else if (sh < -31'sh20000) begin
         s = 18'sh20000;
      end else begin
         s = sh[17:0];
      end
      lm = (18'h00001 << md) - 18'h00001;
      t  = {s[17], s} + ((rdis || md == 4'h0) ? 19'sh00000 : $signed({2'b00, lm[17:1]}) + 19'sh00001);
      if (t > 19'sh1FFFF) begin
         s = 18'sh1FFFF;
      end else begin
         s = t[17:0];
      end
      return s & ~lm; // RL13
   endfunction

   function automatic logic [7:0] mag8(dpm_smp_type y);
      logic [17:0] a;
      a = y[17] ? 18'(-y) : 18'(y);
      if (a[17]) begin
         a = 18'h1FFFF;
      end
      return a[16:9];
   endfunction

   assign gsum = $signed({2'b00, gain_ff}) + adj_ff; // RL15
   assign geff = gsum[25] ? 24'h000000 : (gsum[24] ? 24'hFFFFFF : gsum[23:0]);
   assign ya   = scale(s_i_a, geff, step_ff[`DPM_ST_MD], ctrl_ff[`DPM_CT_RNDD]);
   assign yb   = scale(s_q_a, geff, step_ff[`DPM_ST_MD], ctrl_ff[`DPM_CT_RNDD]);
   assign mag  = (mag8(ya) > mag8(yb)) ? mag8(ya) : mag8(yb);
   assign is_zero = (mag & ~{4'h0, step_ff[`DPM_ST_ZMSK]}) == 8'h00; // RL17
   assign is_max  = (mag == `DPM_MAG_MAX);
   assign up      = (mag <= step_ff[`DPM_ST_THR]); // RL14

   // Step selection
   always_comb begin
      if (mc_ff > cnt_ff[`DPM_CN_MAX]) begin
         dfield = step_ff[`DPM_ST_DSAT]; // RL19 RL25
      end else if (zc_ff > cnt_ff[`DPM_CN_ZERO]) begin
         dfield = step_ff[`DPM_ST_DZRO]; // RL18 RL25
      end else if (!up) begin
         dfield = step_ff[`DPM_ST_DABV]; // RL20
      end else begin
         dfield = step_ff[`DPM_ST_DBLW]; // RL20
      end
   end

   assign dval   = {1'b0, dfield} + `DPM_D_BIAS; // RL16 RL22
   assign delta  = $signed({2'b00, geff}) >>> dval; // RL15
   assign amax_e = 26'($signed({limit_ff[`DPM_LM_AMAX], 8'h00}));
   assign amin_e = 26'($signed({limit_ff[`DPM_LM_AMIN], 8'h00}));
   assign freeze = ctrl_ff[`DPM_CT_FRZ] | (ctrl_ff[`DPM_CT_FSEN] & sync2_ff[fsel]); // RL24

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         zc_ff <= 4'h0;
         mc_ff <= 4'h0;
      end else if (s_valid) begin
         if (is_zero) begin
            zc_ff <= (zc_ff == 4'hF) ? zc_ff : zc_ff + 4'h1; // RL18
         end else begin
            zc_ff <= (zc_ff == 4'h0) ? zc_ff : zc_ff - 4'h1;
         end
         if (is_max) begin
            mc_ff <= (mc_ff == 4'hF) ? mc_ff : mc_ff + 4'h1; // RL19
         end else begin
            mc_ff <= (mc_ff == 4'h0) ? mc_ff : mc_ff - 4'h1;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         adj_ff <= 26'sh0000000;
      end else if (ctrl_ff[`DPM_CT_CLR]) begin
         adj_ff <= 26'sh0000000; // RL24
      end else if (s_valid && !freeze) begin
         if (up && !(adj_ff > amax_e)) begin
            adj_ff <= adj_ff + delta; // RL14 RL23
         end else if (!up && !(adj_ff < amin_e)) begin
            adj_ff <= adj_ff - delta; // RL14 RL23
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         y_valid_ff <= 1'b0;
         y_i_ff     <= 18'sh00000;
         y_q_ff     <= 18'sh00000;
      end else begin
         y_valid_ff <= s_valid;
         if (s_valid) begin
            y_i_ff <= ya; // RL12 RL13
            y_q_ff <= yb;
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_delay_end;
      s_valid && st_ff == DPM_DELAY && dly_cnt_ff == dly_last && !pm_sync;
   endsequence
   sequence s_ivl_end;
      wrap ##1 (smp_cnt_ff == '0 && integ_on_ff);
   endsequence

   property p_latch;
      last_int && ctrl_ff[`DPM_CT_DUAL] |=> pm_ready_ff && res_ff[0] == $past(acc_ff[0] + term[0])
                                          && res_ff[1] == $past(acc_ff[1] + term[1]);
   endproperty
   a_latch: assert property (p_latch) else $error("result not latched on completion"); // RL4
   property p_sync_clr;
      pm_sync |=> st_ff == DPM_DELAY && smp_cnt_ff == '0 && acc_ff[0] == '0 && dly_cnt_ff == 9'h000;
   endproperty
   a_sync_clr: assert property (p_sync_clr) else $error("sync did not clear meter"); // RL7
   property p_delay;
      s_delay_end |=> st_ff == DPM_RUN && smp_cnt_ff == '0;
   endproperty
   a_delay: assert property (p_delay) else $error("integration start mistimed"); // RL3
   property p_wrap;
      wrap |-> s_ivl_end;
   endproperty
   a_wrap: assert property (p_wrap) else $error("interval wrap did not restart counting"); // RL5
   property p_restart;
      wrap && !last_int |=> smp_cnt_ff == '0 && integ_on_ff && !pm_ready_ff;
   endproperty
   a_restart: assert property (p_restart) else $error("interval restart wrong"); // RL5
   property p_count;
      pm_ready_ff |-> $past(smp_cnt_ff) == integ_last && $past(integ_on_ff);
   endproperty
   a_count: assert property (p_count) else $error("ready at wrong sample count"); // RL9
   property p_single;
      !ctrl_ff[`DPM_CT_DUAL] && last_int |=> res_ff[1] == $past(res_ff[1]);
   endproperty
   a_single: assert property (p_single) else $error("second result moved in single mode"); // RL8
   property p_down;
      s_valid && !freeze && !ctrl_ff[`DPM_CT_CLR] && !up && !(adj_ff < amin_e) |=> adj_ff == $past(adj_ff - delta);
   endproperty
   a_down: assert property (p_down) else $error("gain not lowered above threshold"); // RL14
   property p_hold_max;
      s_valid && !ctrl_ff[`DPM_CT_CLR] && up && adj_ff > amax_e |=> adj_ff == $past(adj_ff);
   endproperty
   a_hold_max: assert property (p_hold_max) else $error("adjustment passed upper limit"); // RL23
   property p_freeze;
      freeze && !ctrl_ff[`DPM_CT_CLR] |=> $stable(adj_ff);
   endproperty
   a_freeze: assert property (p_freeze) else $error("adjustment moved while frozen"); // RL24
   property p_round;
      y_valid_ff && $past(s_valid) |-> (y_i_ff & ((18'h00001 << $past(step_ff[`DPM_ST_MD])) - 18'h00001)) == 18'h0;
   endproperty
   a_round: assert property (p_round) else $error("output not rounded to width"); // RL13
   property p_sat_pri;
      mc_ff > cnt_ff[`DPM_CN_MAX] |-> dval == {1'b0, step_ff[`DPM_ST_DSAT]} + `DPM_D_BIAS;
   endproperty
   a_sat_pri: assert property (p_sat_pri) else $error("saturated step not chosen"); // RL25

endmodule // dpm_meter_agc

// ===== dv/dpm_fir_src.sv
`timescale 1ns/100ps
module dpm_fir_src (
   input  wire logic            clk,
   input  wire logic            rst,
   input  wire logic            run,
   input  wire logic            slow,
   input  dpm_pkg::dpm_smp_type i_a,
   input  dpm_pkg::dpm_smp_type q_a,
   input  dpm_pkg::dpm_smp_type i_b,
   input  dpm_pkg::dpm_smp_type q_b,
   output logic                 s_valid,
   output dpm_pkg::dpm_smp_type s_i_a,
   output dpm_pkg::dpm_smp_type s_q_a,
   output dpm_pkg::dpm_smp_type s_i_b,
   output dpm_pkg::dpm_smp_type s_q_b
);
   import dpm_pkg::*;
   logic phase_ff;
   logic send;
   assign send = run && (!slow || phase_ff);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         phase_ff <= 1'b0;
         s_valid  <= 1'b0;
         s_i_a    <= 18'h00000;
         s_q_a    <= 18'h00000;
         s_i_b    <= 18'h00000;
         s_q_b    <= 18'h00000;
      end else begin
         phase_ff <= ~phase_ff;
         s_valid  <= send;
         if (send) begin
            s_i_a <= i_a;
            s_q_a <= q_a;
            s_i_b <= i_b;
            s_q_b <= q_b;
         end else begin
            // Idle lines toggle so stale data never looks like a sample
            s_i_a <= ~s_i_a;
            s_q_a <= ~s_q_a;
            s_i_b <= ~s_i_b;
            s_q_b <= ~s_q_b;
         end
      end
   end
endmodule // dpm_fir_src

// ===== dv/dpm_meter_agc_tb_top.sv
`timescale 1ns/100ps
`include "dpm_consts.svh"
module dpm_meter_agc_tb_top;
   import dpm_pkg::*;
   localparam int FIRST  = 11; // 4 + delay 2 + (4*1+1) integrated
   localparam int PERIOD = 16; // (interval 3 + 1) units of 4 samples
   logic        clk = 1'b0, rst = 1'b0, wr = 1'b0, rd = 1'b0, run = 1'b0, slow = 1'b0;
   logic [7:0]  addr = 8'h00, sync_in = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic        s_valid, pm_ready, y_valid;
   dpm_smp_type i_a = 18'h0, q_a = 18'h0, i_b = 18'h0, q_b = 18'h0;
   dpm_smp_type s_i_a, s_q_a, s_i_b, s_q_b, y_i, y_q;
   int          errors = 0, checks = 0, scnt = 0, gap = 0, nrdy = 0, cyc = 0;

   always #5 clk = ~clk;

   dpm_meter_agc #(.UNIT_LG(2)) dpm_meter_agc_inst (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .s_valid(s_valid), .s_i_a(s_i_a), .s_q_a(s_q_a), .s_i_b(s_i_b),
      .s_q_b(s_q_b), .sync_in(sync_in), .pm_ready(pm_ready), .y_valid(y_valid), .y_i(y_i), .y_q(y_q));
   dpm_fir_src dpm_fir_src_inst (.clk(clk), .rst(rst), .run(run), .slow(slow), .i_a(i_a), .q_a(q_a),
      .i_b(i_b), .q_b(q_b), .s_valid(s_valid), .s_i_a(s_i_a), .s_q_a(s_q_a), .s_i_b(s_i_b), .s_q_b(s_q_b));

   // Samples between ready pulses, plus a cycle ceiling
   always @(posedge clk) begin
      cyc++;
      if (pm_ready === 1'b1) begin
         gap = scnt;
         scnt = 0;
         nrdy++;
      end
      if (s_valid === 1'b1) scnt++;
      if (cyc == 30000) begin
         errors++;
         report_and_stop();
      end
   end

   task report_and_stop;
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(nm, exp, rdata);
   endtask

   task wait_ready(input int n);
      int t;
      t = 0;
      while (nrdy < n && t < 400) begin
         @(posedge clk);
         #1;
         t++;
      end
      chk("ready_seen", 32'h1, 32'(nrdy >= n));
   endtask

   task sync_pulse(input int k);
      @(posedge clk);
      sync_in <= 8'h01 << k;
      repeat (4) @(posedge clk);
      sync_in <= 8'h00;
      repeat (8) @(posedge clk);
   endtask

   task start_meter(input int k);
      int n0;
      @(posedge clk);
      run <= 1'b0;
      repeat (3) @(posedge clk);
      sync_pulse(k);
      #1;
      scnt = 0;
      n0 = nrdy;
      @(posedge clk);
      run <= 1'b1;
      wait_ready(n0 + 1);
      chk("first_gap", FIRST, gap);
   endtask

   task sc_reset;
      rd_chk("ctrl_rst", `DPM_OFF_CTRL, `DPM_RST_WORD);
      rd_chk("gain_rst", `DPM_OFF_GAIN, {8'h00, `DPM_RST_GAIN});
      rd_chk("res_rst", `DPM_OFF_RESALO, `DPM_RST_WORD);
      wr_reg(8'h2C, 32'hFFFF_FFFF);
      rd_chk("unmapped", 8'h2C, 32'h0);
      wr_reg(`DPM_OFF_STEP, 32'hA5C3_0F1E);
      rd_chk("step_rdbk", `DPM_OFF_STEP, 32'hA5C3_0F1E);
      @(posedge clk);
      #1;
      chk("rdata_idle", 32'h0, rdata);
   endtask

   task sc_meter;
      wr_reg(`DPM_OFF_PMCFG, 32'h0302_0001);
      i_a <= 18'h0012C;
      q_a <= 18'h3FE70;
      for (int k = 0; k < 8; k++) begin
         wr_reg(`DPM_OFF_CTRL, 32'h60 | (k << 2));
         start_meter(k);
      end
      rd_chk("res_a_lo", `DPM_OFF_RESALO, 32'h0013_12D0);
      rd_chk("res_a_hi", `DPM_OFF_RESAHI, 32'h0);
      i_a <= 18'h003E8;
      q_a <= 18'h003E8;
      wait_ready(nrdy + 1);
      chk("period_gap", PERIOD, gap);
      rd_chk("res_a_new", `DPM_OFF_RESALO, 32'h0098_9680);
      // A disabled meter or an unselected pin must not restart the count
      for (int v = 0; v < 2; v++) begin
         wr_reg(`DPM_OFF_CTRL, v ? 32'h60 : 32'h62);
         @(posedge clk);
         run <= 1'b0;
         sync_pulse(v ? 3 : 0);
         run <= 1'b1;
         wait_ready(nrdy + 1);
         chk("ign_gap", PERIOD, gap);
      end
   endtask

   task sc_dual;
      wr_reg(`DPM_OFF_CTRL, 32'h61);
      slow <= 1'b1;
      i_a  <= 18'h0012C;
      q_a  <= 18'h3FE70;
      i_b  <= 18'h20000;
      q_b  <= 18'h20000;
      start_meter(0);
      rd_chk("dual_a_lo", `DPM_OFF_RESALO, 32'h0013_12D0);
      rd_chk("dual_b_lo", `DPM_OFF_RESBLO, 32'h0);
      rd_chk("dual_b_hi", `DPM_OFF_RESBHI, 32'h28);
      @(posedge clk);
      slow <= 1'b0;
   endtask

   // A control word with the freeze bit is applied before the new settings, any other after them
   task agc_case(input string nm, input logic [31:0] ctl, gn, stp, cnt, lim, input dpm_smp_type x,
                 input int n, lo, hi);
      if (ctl[5]) wr_reg(`DPM_OFF_CTRL, ctl);
      wr_reg(`DPM_OFF_GAIN, gn);
      wr_reg(`DPM_OFF_STEP, stp);
      wr_reg(`DPM_OFF_CNT, cnt);
      wr_reg(`DPM_OFF_LIMIT, lim);
      i_a <= x;
      q_a <= x;
      if (!ctl[5]) wr_reg(`DPM_OFF_CTRL, ctl);
      repeat (n) @(posedge clk);
      #1;
      checks++;
      if (y_valid !== 1'b1 || $isunknown({y_i, y_q}) || y_i < lo || y_i > hi || y_q < lo || y_q > hi) begin
         errors++;
         $display("BAD %s expected %0d..%0d seen %0d %0d", nm, lo, hi, y_i, y_q);
      end
   endtask

   task sc_agc;
      @(posedge clk);
      run <= 1'b1;
      agc_case("unity", 32'h60, 32'h1000, 32'h0, 32'h0, 32'h8000_7FFF, 18'h003E8, 6, 1000, 1000);
      agc_case("gain2", 32'h60, 32'h2000, 32'h0, 32'h0, 32'h8000_7FFF, 18'h003E8, 6, 2000, 2000);
      agc_case("atten", 32'h60, 32'h0800, 32'h0, 32'h0, 32'h8000_7FFF, 18'h003E8, 6, 500, 500);
      agc_case("sat_pos", 32'h60, 32'h2000, 32'h0, 32'h0, 32'h8000_7FFF, 18'h1FFFF, 6, 131071, 131071);
      agc_case("sat_neg", 32'h60, 32'h2000, 32'h0, 32'h0, 32'h8000_7FFF, 18'h20000, 6, -131072, -131072);
      agc_case("round", 32'h60, 32'h1000, 32'h0040_0000, 32'h0, 32'h8000_7FFF, 18'h003FC, 6, 1024, 1024);
      agc_case("trunc", 32'hE0, 32'h1000, 32'h0040_0000, 32'h0, 32'h8000_7FFF, 18'h003FC, 6, 1008, 1008);
      agc_case("width4", 32'h60, 32'h1000, 32'h00E0_0000, 32'h0, 32'h8000_7FFF, 18'h186A0, 6, 98304, 98304);
      agc_case("rise", 32'h0, 32'h1000, 32'h8000_0000, 32'h0, 32'hFFF0_0010, 18'h00040, 200, 128, 150);
      agc_case("clr1", 32'h60, 32'h1000, 32'h0, 32'h0, 32'h8000_7FFF, 18'h003E8, 6, 1000, 1000);
      agc_case("fall", 32'h0, 32'h1000, 32'h0100_0000, 32'h0, 32'hFFF8_7FFF, 18'h186A0, 200, 40000, 50000);
      agc_case("frozen", 32'h20, 32'h1000, 32'hFF00_0000, 32'h0, 32'h8000_7FFF, 18'h186A0, 100, 40000, 50000);
      // Freeze now held only by sync pin 1 through the freeze source select
      sync_in <= 8'h02;
      agc_case("frz_sync", 32'h300, 32'h1000, 32'hFF00_0000, 32'h0, 32'h8000_7FFF, 18'h186A0, 100, 40000, 50000);
      sync_in <= 8'h00;
      agc_case("clr2", 32'h60, 32'h1000, 32'h0, 32'h0, 32'h8000_7FFF, 18'h003E8, 6, 1000, 1000);
      agc_case("satstep", 32'h0, 32'h1000, 32'h0100_00FF, 32'h1F, 32'h8000_7FFF, 18'h1FFFF, 30, 60000, 125000);
      agc_case("clr3", 32'h60, 32'h1000, 32'h0, 32'h0, 32'h8000_7FFF, 18'h003E8, 6, 1000, 1000);
      agc_case("zerostep", 32'h0, 32'h1000, 32'h8000_F0FF, 32'hF1, 32'h8000_7FFF, 18'h00004, 40, 30, 4000);
      agc_case("clr4", 32'h60, 32'h1000, 32'h0, 32'h0, 32'h8000_7FFF, 18'h003E8, 6, 1000, 1000);
      agc_case("zeromask", 32'h0, 32'h1000, 32'h800F_F0FF, 32'hF1, 32'h8000_7FFF, 18'h01000, 40, 8192, 80000);
   endtask

   initial begin
      rst = 1'b1;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      sc_reset();
      sc_meter();
      sc_dual();
      sc_agc();
      report_and_stop();
   end
endmodule // dpm_meter_agc_tb_top
